// *** verilog/mso_pkg.sv ***
// Constants, field layout and mode types of the motion status output block
// Summary of operation
// - Done when error below done width
// - Done output high means positioning complete
// - Timing mode adds filtered or raw reference zero
// - Done output only valid in position control
// - Close output high while error below close width
// - Close width 1 to 2^30, default 2^30
// - Clamp output high in force control while speed at active limit
// - Force control limits speed only through clamp
// - Source select picks internal or commanded limit
// - Internal ceiling 0 to 10000, default 10000
// - Internal limit is min with selected basis; commanded limit is used as is
// - No terminal driven until an assignment exists
package mso_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int REF_CLK_MHZ = 20;
    localparam int CTRL_PERIOD_NS = 62500;
    localparam int CTRL_DIV = REF_CLK_MHZ * CTRL_PERIOD_NS / 1000;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PEND = 8'h04;
    localparam logic [7:0] ADDR_DONE_W = 8'h08;
    localparam logic [7:0] ADDR_CLOSE_W = 8'h0C;
    localparam logic [7:0] ADDR_INT_CEIL = 8'h10;
    localparam logic [7:0] ADDR_ASSIGN = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_RESTART_BIT = 0;
    localparam int PEND_TIMING_LSB = 0;
    localparam int PEND_SRC_BIT = 4;
    localparam int PEND_BASIS_BIT = 8;
    localparam int ASSIGN_A_LSB = 0;
    localparam int ASSIGN_B_LSB = 4;
    localparam int ASSIGN_C_LSB = 8;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_CLOSE_BIT = 1;
    localparam int ST_CLAMP_BIT = 2;
    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [30:0] DONE_W_RST = 31'h00000007;
    localparam logic [30:0] CLOSE_W_RST = 31'h40000000;
    localparam logic [30:0] WIDTH_MAX = 31'h40000000;
    localparam logic [15:0] INT_CEIL_RST = 16'h2710;
    localparam logic [15:0] INT_CEIL_MAX = 16'h2710;
    localparam logic [3:0] ASSIGN_RST = 4'h0;
    typedef enum logic [1:0] {MSO_TIMING_ERR, MSO_TIMING_FILT, MSO_TIMING_RAW} mso_timing_e;
endpackage

// *** verilog/mso_tick_div.sv ***
// Control cycle enable divider
`timescale 1ns/1ps
module mso_tick_div #(
    parameter int DIV = mso_pkg::CTRL_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Enable pulse
    output logic tick
);
    logic [15:0] cnt_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// *** verilog/mso_speed_limit.sv ***
// Effective force control speed limit selection
`timescale 1ns/1ps
module mso_speed_limit (
    // Settings
    input wire logic [15:0] internal_speed_ceiling,
    input wire logic ceiling_basis_select,
    input wire logic limit_source_select,
    // Speeds from the drive
    input wire logic [15:0] motor_max_speed,
    input wire logic [15:0] overspeed_level,
    input wire logic [15:0] commanded_speed_ceiling,
    // Result
    output logic [15:0] limit
);
    logic [15:0] basis;
    logic [15:0] int_lim;

    // Internal setting never exceeds the chosen basis speed
    assign basis = ceiling_basis_select ? overspeed_level : motor_max_speed;
    assign int_lim = (internal_speed_ceiling < basis) ? internal_speed_ceiling : basis;
    assign limit = limit_source_select ? commanded_speed_ceiling : int_lim;
endmodule

// *** verilog/mso_status_out.sv ***
// Positioning done, close and speed clamp status outputs with register port
`timescale 1ns/1ps
module mso_status_out #(
    parameter int CTRL_DIV = mso_pkg::CTRL_DIV,
    parameter int OUT_N = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Position loop
    input wire logic pos_ctrl_mode,
    input wire logic [31:0] ref_count,
    input wire logic [31:0] travel_count,
    input wire logic filt_ref_idle,
    input wire logic raw_ref_idle,
    // Speed loop
    input wire logic force_ctrl_mode,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] motor_max_speed,
    input wire logic [15:0] overspeed_level,
    input wire logic [15:0] commanded_speed_ceiling,
    output logic [15:0] speed_limit_out,
    // Status
    output logic position_done_out,
    output logic position_close_out,
    output logic speed_clamp_active_out,
    output logic [OUT_N-1:0] out_term,
    output logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [30:0] clamp_width(input logic [31:0] v, input logic [30:0] lo);
        logic [30:0] r;
        r = v[30:0];
        if (v > {1'b0, mso_pkg::WIDTH_MAX}) begin
            r = mso_pkg::WIDTH_MAX;
        end
        if (r < lo) begin
            r = lo;
        end
        return r;
    endfunction

    function automatic logic hit(input logic [3:0] asg, input int idx);
        return asg == 4'(idx + 1);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic tick;
    logic [30:0] done_w_q;
    logic [30:0] close_w_q;
    logic [15:0] int_ceil_q;
    logic [1:0] pend_timing_q;
    logic pend_src_q;
    logic pend_basis_q;
    mso_pkg::mso_timing_e timing_q;
    logic src_q;
    logic basis_q;
    logic [3:0] asg_a_q;
    logic [3:0] asg_b_q;
    logic [3:0] asg_c_q;
    logic [2:0] irq_st_q;
    logic [2:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic [32:0] err_s;
    logic [32:0] err_abs;
    logic err_in_done;
    logic err_in_close;
    logic ref_ok;
    logic done_d;
    logic close_d;
    logic [15:0] speed_abs;
    logic [15:0] limit_c;
    logic clamp_d;
    logic wr_ctrl;
    logic [2:0] ev;
    logic [2:0] st_now;

    // ----------------------------------------
    // Control cycle enable and speed limit
    // ----------------------------------------
    mso_tick_div #(
        .DIV(CTRL_DIV)
    ) u_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    mso_speed_limit u_lim (
        .internal_speed_ceiling(int_ceil_q),
        .ceiling_basis_select(basis_q),
        .limit_source_select(src_q),
        .motor_max_speed(motor_max_speed),
        .overspeed_level(overspeed_level),
        .commanded_speed_ceiling(commanded_speed_ceiling),
        .limit(limit_c)
    );

    // ----------------------------------------
    // Settings written by software
    // ----------------------------------------
    // Widths and ceiling act on the next control cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_w_q <= mso_pkg::DONE_W_RST;
            close_w_q <= mso_pkg::CLOSE_W_RST;
            int_ceil_q <= mso_pkg::INT_CEIL_RST;
        end else if (reg_wr) begin
            if (reg_addr == mso_pkg::ADDR_DONE_W) begin
                done_w_q <= clamp_width(reg_wdata, 31'h00000000);
            end
            if (reg_addr == mso_pkg::ADDR_CLOSE_W) begin
                close_w_q <= clamp_width(reg_wdata, 31'h00000001);
            end
            if (reg_addr == mso_pkg::ADDR_INT_CEIL) begin
                if (reg_wdata > {16'h0000, mso_pkg::INT_CEIL_MAX}) begin
                    int_ceil_q <= mso_pkg::INT_CEIL_MAX;
                end else begin
                    int_ceil_q <= reg_wdata[15:0];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            asg_a_q <= mso_pkg::ASSIGN_RST;
            asg_b_q <= mso_pkg::ASSIGN_RST;
            asg_c_q <= mso_pkg::ASSIGN_RST;
        end else if (reg_wr && reg_addr == mso_pkg::ADDR_ASSIGN) begin
            asg_a_q <= reg_wdata[mso_pkg::ASSIGN_A_LSB +: 4];
            asg_b_q <= reg_wdata[mso_pkg::ASSIGN_B_LSB +: 4];
            asg_c_q <= reg_wdata[mso_pkg::ASSIGN_C_LSB +: 4];
        end
    end

    // Mode selectors are staged and only take hold on a restart
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_timing_q <= 2'h0;
            pend_src_q <= 1'b0;
            pend_basis_q <= 1'b0;
        end else if (reg_wr && reg_addr == mso_pkg::ADDR_PEND) begin
            pend_timing_q <= reg_wdata[mso_pkg::PEND_TIMING_LSB +: 2];
            pend_src_q <= reg_wdata[mso_pkg::PEND_SRC_BIT];
            pend_basis_q <= reg_wdata[mso_pkg::PEND_BASIS_BIT];
        end
    end

    assign wr_ctrl = reg_wr && reg_addr == mso_pkg::ADDR_CTRL && reg_wdata[mso_pkg::CTRL_RESTART_BIT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_q <= mso_pkg::MSO_TIMING_ERR;
            src_q <= 1'b0;
            basis_q <= 1'b0;
        end else if (wr_ctrl) begin
            case (pend_timing_q)
                2'h1: timing_q <= mso_pkg::MSO_TIMING_FILT;
                2'h2: timing_q <= mso_pkg::MSO_TIMING_RAW;
                default: timing_q <= mso_pkg::MSO_TIMING_ERR;
            endcase
            src_q <= pend_src_q;
            basis_q <= pend_basis_q;
        end
    end

    // ----------------------------------------
    // Position error compare
    // ----------------------------------------
    // Error is taken at 33 bits so a full-range difference cannot wrap
    assign err_s = {ref_count[31], ref_count} - {travel_count[31], travel_count};
    assign err_abs = err_s[32] ? (33'h000000000 - err_s) : err_s;
    assign err_in_done = err_abs < {2'b00, done_w_q};
    assign err_in_close = err_abs < {2'b00, close_w_q};

    always_comb begin
        case (timing_q)
            mso_pkg::MSO_TIMING_FILT: ref_ok = filt_ref_idle;
            mso_pkg::MSO_TIMING_RAW: ref_ok = raw_ref_idle;
            default: ref_ok = 1'b1;
        endcase
    end

    assign done_d = pos_ctrl_mode && err_in_done && ref_ok;
    assign close_d = err_in_close;

    // ----------------------------------------
    // Speed clamp
    // ----------------------------------------
    assign speed_abs = motor_speed[15] ? (16'h0000 - motor_speed) : motor_speed;
    // Speed is left free in force control; only the clamp holds it
    assign clamp_d = force_ctrl_mode && (speed_abs >= limit_c);

    // ----------------------------------------
    // Status outputs, one update per control cycle
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            position_done_out <= 1'b0;
            position_close_out <= 1'b0;
            speed_clamp_active_out <= 1'b0;
            speed_limit_out <= 16'h0000;
        end else if (tick) begin
            position_done_out <= done_d;
            position_close_out <= close_d;
            speed_clamp_active_out <= clamp_d;
            speed_limit_out <= limit_c;
        end
    end

    // Unassigned signals reach no terminal; code 0 means none
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_term <= '0;
        end else begin
            for (int i = 0; i < OUT_N; i++) begin
                out_term[i] <= (hit(asg_a_q, i) && position_done_out)
                    || (hit(asg_b_q, i) && position_close_out)
                    || (hit(asg_c_q, i) && speed_clamp_active_out);
            end
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    assign st_now = {clamp_d, close_d, done_d};
    assign ev = tick ? (st_now & ~{speed_clamp_active_out, position_close_out, position_done_out}) : 3'h0;

    // A rising event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q <= 3'h0;
        end else if (reg_wr && reg_addr == mso_pkg::ADDR_IRQ_ST) begin
            irq_st_q <= (irq_st_q & ~reg_wdata[2:0]) | ev;
        end else begin
            irq_st_q <= irq_st_q | ev;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= 3'h0;
        end else if (reg_wr && reg_addr == mso_pkg::ADDR_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[2:0];
        end
    end

    assign irq = |(irq_st_q & irq_mask_q);

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                mso_pkg::ADDR_PEND: rdata_q <= {23'h0, pend_basis_q, 3'h0, pend_src_q, 2'h0, pend_timing_q};
                mso_pkg::ADDR_DONE_W: rdata_q <= {1'b0, done_w_q};
                mso_pkg::ADDR_CLOSE_W: rdata_q <= {1'b0, close_w_q};
                mso_pkg::ADDR_INT_CEIL: rdata_q <= {16'h0000, int_ceil_q};
                mso_pkg::ADDR_ASSIGN: rdata_q <= {20'h0, asg_c_q, asg_b_q, asg_a_q};
                mso_pkg::ADDR_STATUS: rdata_q <= {basis_q, src_q, timing_q, 8'h0, speed_limit_out,
                    1'b0, speed_clamp_active_out, position_close_out, position_done_out};
                mso_pkg::ADDR_IRQ_ST: rdata_q <= {29'h0, irq_st_q};
                mso_pkg::ADDR_IRQ_MASK: rdata_q <= {29'h0, irq_mask_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_done_wide;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && !err_in_done |=> !position_done_out;
    endproperty
    a_done_wide: assert property (p_done_wide) else $error("done high with error outside width");

    property p_done_mode;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && !pos_ctrl_mode |=> !position_done_out;
    endproperty
    a_done_mode: assert property (p_done_mode) else $error("done high outside position control");

    property p_done_set;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && pos_ctrl_mode && err_in_done && timing_q == mso_pkg::MSO_TIMING_ERR |=> position_done_out;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done low with error inside width");

    property p_timing_filt;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && timing_q == mso_pkg::MSO_TIMING_FILT && !filt_ref_idle |=> !position_done_out;
    endproperty
    a_timing_filt: assert property (p_timing_filt) else $error("done high with filtered reference moving");

    property p_timing_raw;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && timing_q == mso_pkg::MSO_TIMING_RAW && !raw_ref_idle |=> !position_done_out;
    endproperty
    a_timing_raw: assert property (p_timing_raw) else $error("done high with raw reference moving");

    logic [32:0] err_abs_past;
    always_ff @(posedge ref_clk) err_abs_past <= err_abs;
    property p_close;
        @(posedge ref_clk) disable iff (!rst_n)
        tick |=> position_close_out == (err_abs_past < {2'b00, $past(close_w_q)});
    endproperty
    a_close: assert property (p_close) else $error("close output disagrees with width");

    property p_close_w;
        @(posedge ref_clk) disable iff (!rst_n)
        close_w_q != 31'h00000000 && close_w_q <= mso_pkg::WIDTH_MAX;
    endproperty
    a_close_w: assert property (p_close_w) else $error("close width out of range");

    property p_ceil;
        @(posedge ref_clk) disable iff (!rst_n)
        int_ceil_q <= mso_pkg::INT_CEIL_MAX;
    endproperty
    a_ceil: assert property (p_ceil) else $error("internal ceiling above maximum");

    property p_clamp_force;
        @(posedge ref_clk) disable iff (!rst_n)
        tick && (!force_ctrl_mode || speed_abs < limit_c) |=> !speed_clamp_active_out;
    endproperty
    a_clamp_force: assert property (p_clamp_force) else $error("clamp flagged without limiting");

    property p_no_assign;
        @(posedge ref_clk) disable iff (!rst_n)
        asg_a_q == 4'h0 && asg_b_q == 4'h0 && asg_c_q == 4'h0 ##1 $stable(asg_a_q) |-> out_term == '0;
    endproperty
    a_no_assign: assert property (p_no_assign) else $error("terminal driven without assignment");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        !tick |=> $stable(position_done_out) && $stable(speed_clamp_active_out);
    endproperty
    a_hold: assert property (p_hold) else $error("status changed outside control cycle");

    c_done: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(position_done_out));
    c_clamp: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(speed_clamp_active_out));
    c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
endmodule

// *** verif/mso_host_model.sv ***
// Host motion controller model that reads the discrete status terminals
`timescale 1ns/1ps
module mso_host_model #(
    parameter int N = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Terminals from the drive
    input wire logic [N-1:0] out_term,
    // What the host has latched
    output logic [N-1:0] seen_term
);
    // --------------------------------
    // Contact sampling
    // --------------------------------
    // One register stage, as a real input card would add; closed reads as high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_term <= '0;
        end else begin
            seen_term <= out_term;
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the motion status output block
`timescale 1ns/1ps
module testbench;
    localparam int DIV = 4;
    logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pos_ctrl_mode = 0;
    logic filt_ref_idle = 0, raw_ref_idle = 0, force_ctrl_mode = 0, irq;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, ref_count = 0, travel_count = 0, base;
    logic [15:0] motor_speed = 0, motor_max_speed = 16'h1388, overspeed_level = 16'h1770;
    logic [15:0] commanded_speed_ceiling = 16'h0BB8, speed_limit_out, ceil = 16'h2710;
    logic position_done_out, position_close_out, speed_clamp_active_out, rd_seen = 0;
    logic [2:0] out_term, seen_term;
    logic [31:0] exp_q[$], msk_q[$], e, m;
    int mismatches = 0, check_count = 0, dw = 7, cw = 32'h40000000, t = 0, src = 0, basis = 0;
    int asg = 0;
    int errs[8] = '{6, 7, -7, -6, 99, 100, -100, 0};
    int spds[6] = '{3999, 4000, -5000, 4999, 5999, 6000};
    always #25 ref_clk = ~ref_clk;
    mso_status_out #(.CTRL_DIV(DIV), .OUT_N(3)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pos_ctrl_mode(pos_ctrl_mode), .ref_count(ref_count),
        .travel_count(travel_count), .filt_ref_idle(filt_ref_idle), .raw_ref_idle(raw_ref_idle),
        .force_ctrl_mode(force_ctrl_mode), .motor_speed(motor_speed), .motor_max_speed(motor_max_speed),
        .overspeed_level(overspeed_level), .commanded_speed_ceiling(commanded_speed_ceiling),
        .speed_limit_out(speed_limit_out), .position_done_out(position_done_out),
        .position_close_out(position_close_out), .speed_clamp_active_out(speed_clamp_active_out),
        .out_term(out_term), .irq(irq));
    mso_host_model #(.N(3)) i_host (.ref_clk(ref_clk), .rst_n(rst_n), .out_term(out_term),
        .seen_term(seen_term));
    // --------------------------------
    // Checking helpers
    // --------------------------------
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, act, exp);
            mismatches++;
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so look exactly there
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(reg_rdata & m, e & m);
        end
        rd_seen <= reg_rd;
    end
    // --------------------------------
    // Register bus
    // --------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k = 32'hFFFFFFFF);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(x);
        msk_q.push_back(k);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic chk_irq(input logic x);
        @(negedge ref_clk);
        chk({31'h0, irq}, {31'h0, x});
    endtask
    // --------------------------------
    // Apply a position error and speed, then compare every status pin except irq
    // --------------------------------
    task automatic set(input int err, input int sp);
        int ae, as, lim, b, d, c, k;
        logic [2:0] tx;
        @(posedge ref_clk);
        ref_count <= base + err;
        travel_count <= base;
        motor_speed <= sp[15:0];
        repeat (2 * DIV + 4) @(posedge ref_clk);
        ae = err < 0 ? -err : err;
        as = sp < 0 ? -sp : sp;
        b = basis ? overspeed_level : motor_max_speed;
        lim = src ? commanded_speed_ceiling : (ceil < b ? ceil : b);
        d = pos_ctrl_mode && ae < dw && (t == 1 ? filt_ref_idle : t == 2 ? raw_ref_idle : 1'b1);
        c = ae < cw;
        k = force_ctrl_mode && as >= lim;
        for (int i = 0; i < 3; i++) begin
            tx[i] = (asg[3:0] == i + 1 && d) || (asg[7:4] == i + 1 && c) || (asg[11:8] == i + 1 && k);
        end
        chk(position_done_out, d);
        chk(position_close_out, c);
        chk(speed_clamp_active_out, k);
        chk(speed_limit_out, lim);
        chk(seen_term, tx);
    endtask
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        void'($urandom(32'h830e));
        // Keep the base clear of zero so a negative error never wraps the reference count
        base = ($urandom & 32'h0FFFFFFF) | 32'h00001000;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(mso_pkg::ADDR_DONE_W, 32'h7);
        rd(mso_pkg::ADDR_CLOSE_W, 32'h40000000);
        rd(mso_pkg::ADDR_INT_CEIL, 32'h2710);
        rd(mso_pkg::ADDR_ASSIGN, 32'h0);
        rd(mso_pkg::ADDR_CTRL, 32'h0);
        rd(8'h24, 32'h0);
        @(posedge ref_clk);
        pos_ctrl_mode <= 1'b1;
        set(0, 0);
        wr(mso_pkg::ADDR_DONE_W, 32'hFFFFFFFF);
        rd(mso_pkg::ADDR_DONE_W, 32'h40000000);
        wr(mso_pkg::ADDR_CLOSE_W, 32'h0);
        rd(mso_pkg::ADDR_CLOSE_W, 32'h1);
        wr(mso_pkg::ADDR_INT_CEIL, 32'hFFFF);
        rd(mso_pkg::ADDR_INT_CEIL, 32'h2710);
        // Close width above done width, as a careful host sets it
        wr(mso_pkg::ADDR_DONE_W, 32'h7);
        wr(mso_pkg::ADDR_CLOSE_W, 32'h64);
        dw = 7;
        cw = 100;
        asg = 32'h321;
        wr(mso_pkg::ADDR_ASSIGN, asg);
        rd(mso_pkg::ADDR_ASSIGN, asg);
        foreach (errs[i]) set(errs[i], 0);
        for (int i = 0; i < 4; i++) set($urandom_range(0, 200) - 100, 0);
        @(posedge ref_clk);
        pos_ctrl_mode <= 1'b0;
        set(0, 0);
        @(posedge ref_clk);
        pos_ctrl_mode <= 1'b1;
        for (int md = 1; md < 3; md++) begin
            wr(mso_pkg::ADDR_PEND, md);
            rd(mso_pkg::ADDR_PEND, md);
            set(0, 0);
            wr(mso_pkg::ADDR_CTRL, 32'h1);
            t = md;
            rd(mso_pkg::ADDR_STATUS, {2'b00, md[1:0], 28'h0}, 32'h30000000);
            for (int f = 0; f < 4; f++) begin
                @(posedge ref_clk);
                filt_ref_idle <= f[0];
                raw_ref_idle <= f[1];
                set(0, 0);
            end
        end
        @(posedge ref_clk);
        force_ctrl_mode <= 1'b1;
        for (int cf = 0; cf < 4; cf++) begin
            ceil = cf == 3 ? 16'h0FA0 : 16'h1F40;
            wr(mso_pkg::ADDR_INT_CEIL, ceil);
            wr(mso_pkg::ADDR_PEND, cf == 1 ? 32'h100 : cf == 2 ? 32'h10 : 32'h0);
            wr(mso_pkg::ADDR_CTRL, 32'h1);
            t = 0;
            basis = cf == 1;
            src = cf == 2;
            foreach (spds[i]) set(0, spds[i]);
            rd(mso_pkg::ADDR_STATUS, {basis[0], src[0], 30'h0}, 32'hFFF00008);
            set(0, $urandom_range(0, 9000));
        end
        @(posedge ref_clk);
        force_ctrl_mode <= 1'b0;
        set(0, 9000);
        rd(mso_pkg::ADDR_STATUS, 32'h0000FA03);
        wr(mso_pkg::ADDR_IRQ_MASK, 32'h1);
        rd(mso_pkg::ADDR_IRQ_MASK, 32'h1);
        set(50, 0);
        wr(mso_pkg::ADDR_IRQ_ST, 32'h7);
        chk_irq(1'b0);
        set(0, 0);
        chk_irq(1'b1);
        rd(mso_pkg::ADDR_IRQ_ST, 32'h1, 32'h1);
        wr(mso_pkg::ADDR_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        wr(mso_pkg::ADDR_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(mso_pkg::ADDR_IRQ_ST, 32'h1);
        chk_irq(1'b0);
        rd(mso_pkg::ADDR_IRQ_ST, 32'h0, 32'h1);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge ref_clk);
        if (exp_q.size() > 0) mismatches++;
        test_done();
    end
    // Cut a hang short
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
endmodule
